//--- rtl/dpol_pkg.sv
// Purpose: Constants and carrier types for the panel signal polarity and
//          pad enable block.
// Assumes: 32-bit AXI4-Lite register bus on mclk, panel logic on lnk_clk.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
//
// How it works
// - Clock polarity picks glass clock capture edge
// - TFT mode: enable polarity sets active level
// - STN mode: enable is shift clock or toggle
// - Vsync polarity bit sets vsync active level
// - Hsync polarity bit sets hsync active level
// - Vsync port enable connects vsync to pin
// - Hsync port enable connects hsync to pin
// - Port enables need master pad enable set
// - Power sequencer bit drives power port high
package dpol_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0]  DPOL_ADDR_CTL3   = 8'h00;
   localparam logic [7:0]  DPOL_ADDR_CTL2   = 8'h04;
   localparam logic [7:0]  DPOL_ADDR_STAT   = 8'h08;
   localparam logic [15:0] DPOL_CTL3_RESET  = 16'h0000;
   localparam logic [2:0]  DPOL_MODE_RESET  = 3'h0;

   // Field positions in display_output_control_three
   localparam int DPOL_B_HSYNC_OE   = 0;
   localparam int DPOL_B_VSYNC_OE   = 1;
   localparam int DPOL_B_EN_OE      = 2;
   localparam int DPOL_B_PWR_OE     = 3;
   localparam int DPOL_B_HSYNC_POL  = 4;
   localparam int DPOL_B_VSYNC_POL  = 5;
   localparam int DPOL_B_EN_POL     = 6;
   localparam int DPOL_B_CLK_POL    = 7;
   localparam int DPOL_B_PWR_VAL    = 8;
   localparam int DPOL_B_MASTER_OE  = 9;
   localparam int DPOL_CTL3_TOP     = 9;

   // display_type_select codes in display_control_two
   localparam logic [2:0] DPOL_MODE_TFT  = 3'h1;
   localparam logic [2:0] DPOL_MODE_STN4 = 3'h2;
   localparam logic [2:0] DPOL_MODE_STN8 = 3'h3;

   // AXI responses
   localparam logic [1:0] DPOL_RESP_OKAY   = 2'h0;
   localparam logic [1:0] DPOL_RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } dpol_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dpol_axi_rsp_t;

   // Raw timing from the generator, active high, on lnk_clk
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic data_enable;
      logic shift_clock;
      logic line_toggle;
   } dpol_timing_t;

   // Panel pins: each but the glass clock has a level and an output enable
   typedef struct packed {
      logic panel_glass_clock;
      logic panel_enable_signal;
      logic panel_enable_signal_oe;
      logic panel_power_seq_port;
      logic panel_power_seq_port_oe;
      logic vsync;
      logic vsync_oe;
      logic hsync;
      logic hsync_oe;
   } dpol_pins_t;

endpackage : dpol_pkg

//--- rtl/dpol_port_ctrl.sv
// Purpose: Polarity and pad enable stage between the display timing
//          generator and the panel pins, with its control registers.
// Assumes: Timing inputs are produced on lnk_clk; software reaches the
//          registers over AXI4-Lite on mclk.
// Notes:   Control bits cross to lnk_clk as levels; they are meant to be
//          set up while the panel is idle.
module dpol_port_ctrl (
   // System clock and reset
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   // Register bus
   input  wire dpol_pkg::dpol_axi_req_t axi_req,
   output      dpol_pkg::dpol_axi_rsp_t axi_rsp,
   // Panel link clock and timing from the generator
   input  wire logic                   lnk_clk,
   input  wire dpol_pkg::dpol_timing_t  timing,
   // Panel pins
   output      dpol_pkg::dpol_pins_t    pins
);
   import dpol_pkg::*;

   // -------------------------------------------------------------------
   // State of the bus side
   // -------------------------------------------------------------------
   typedef struct packed {
      dpol_axi_rsp_t rsp;
      logic          aw_have;
      logic [7:0]    aw_addr;
      logic          w_have;
      logic [31:0]   w_data;
      logic [3:0]    w_strb;
      logic [15:0]   ctl3;
      logic [2:0]    mode;
      logic [3:0]    stat_s1;
      logic [3:0]    stat_s2;
   } dpol_bus_t;

   // -------------------------------------------------------------------
   // State of the link side
   // -------------------------------------------------------------------
   typedef struct packed {
      logic          rst_s1;
      logic          rst_s2;
      logic [15:0]   cfg_s1;
      logic [15:0]   cfg_s2;
      logic [2:0]    mode_s1;
      logic [2:0]    mode_s2;
      logic          phase;
      dpol_pins_t    pins;
   } dpol_lnk_t;

   dpol_bus_t bq;
   dpol_bus_t bd;
   dpol_lnk_t lq;
   dpol_lnk_t ld;

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   function automatic logic [31:0] dpol_read(
      input logic [7:0]  addr,
      input logic [15:0] ctl3,
      input logic [2:0]  mode,
      input logic [3:0]  stat
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (addr)
         DPOL_ADDR_CTL3: v[DPOL_CTL3_TOP:0] = ctl3[DPOL_CTL3_TOP:0];
         DPOL_ADDR_CTL2: v[2:0]             = mode;
         DPOL_ADDR_STAT: v[3:0]             = stat;
         default:        v                  = 32'h0000_0000;
      endcase
      return v;
   endfunction : dpol_read

   function automatic logic dpol_mapped(input logic [7:0] addr);
      return (addr == DPOL_ADDR_CTL3) || (addr == DPOL_ADDR_CTL2) ||
             (addr == DPOL_ADDR_STAT);
   endfunction : dpol_mapped

   // -------------------------------------------------------------------
   // Bus side next state
   // -------------------------------------------------------------------
   always_comb begin
      bd = bq;

      // Address and data are taken independently, in either order
      if (axi_req.awvalid && bq.rsp.awready) begin
         bd.aw_have = 1'b1;
         bd.aw_addr = {axi_req.awaddr[7:2], 2'b00};
      end
      if (axi_req.wvalid && bq.rsp.wready) begin
         bd.w_have = 1'b1;
         bd.w_data = axi_req.wdata;
         bd.w_strb = axi_req.wstrb;
      end

      if (bq.rsp.bvalid && axi_req.bready) begin
         bd.rsp.bvalid = 1'b0;
      end

      // Commit once both halves are held and no response is pending
      if (bq.aw_have && bq.w_have && !bq.rsp.bvalid) begin
         bd.aw_have    = 1'b0;
         bd.w_have     = 1'b0;
         bd.rsp.bvalid = 1'b1;
         bd.rsp.bresp  = dpol_mapped(bq.aw_addr) ? DPOL_RESP_OKAY
                                                 : DPOL_RESP_SLVERR;
         if (bq.aw_addr == DPOL_ADDR_CTL3) begin
            if (bq.w_strb[0]) begin
               bd.ctl3[7:0] = bq.w_data[7:0];
            end
            // Bits 15..10 are unimplemented and stay zero
            if (bq.w_strb[1]) begin
               bd.ctl3[DPOL_CTL3_TOP:8] = bq.w_data[DPOL_CTL3_TOP:8];
            end
         end
         if (bq.aw_addr == DPOL_ADDR_CTL2 && bq.w_strb[0]) begin
            bd.mode = bq.w_data[2:0];
         end
      end

      // Holding a half blocks the next one of the same kind
      bd.rsp.awready = !bd.aw_have;
      bd.rsp.wready  = !bd.w_have;

      // Read channel: one read at a time, answered one cycle after taken
      if (bq.rsp.rvalid && axi_req.rready) begin
         bd.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && bq.rsp.arready) begin
         bd.rsp.rvalid = 1'b1;
         bd.rsp.rdata  = dpol_read({axi_req.araddr[7:2], 2'b00}, bq.ctl3,
                                   bq.mode, bq.stat_s2);
         bd.rsp.rresp  = dpol_mapped({axi_req.araddr[7:2], 2'b00})
                         ? DPOL_RESP_OKAY : DPOL_RESP_SLVERR;
      end
      bd.rsp.arready = !bd.rsp.rvalid;

      // Pad states come back from the link side as plain levels
      bd.stat_s1 = {lq.pins.panel_power_seq_port_oe,
                    lq.pins.panel_enable_signal_oe,
                    lq.pins.vsync_oe,
                    lq.pins.hsync_oe};
      bd.stat_s2 = bq.stat_s1;

      if (!resetn) begin
         bd             = '0;
         bd.ctl3        = DPOL_CTL3_RESET;
         bd.mode        = DPOL_MODE_RESET;
         bd.rsp.bresp   = DPOL_RESP_OKAY;
         bd.rsp.rresp   = DPOL_RESP_OKAY;
      end
   end

   always_ff @(posedge mclk) begin
      bq <= bd;
   end

   assign axi_rsp = bq.rsp;

   // -------------------------------------------------------------------
   // Link side next state
   // -------------------------------------------------------------------
   logic       clk_pol;
   logic       en_pol;
   logic       master_oe;
   logic       launch;
   logic       gen_level;

   always_comb begin
      ld = lq;

      // Synchronisers: the first stage feeds only the second
      ld.rst_s1  = resetn;
      ld.rst_s2  = lq.rst_s1;
      ld.cfg_s1  = bq.ctl3;
      ld.cfg_s2  = lq.cfg_s1;
      ld.mode_s1 = bq.mode;
      ld.mode_s2 = lq.mode_s1;

      clk_pol   = lq.cfg_s2[DPOL_B_CLK_POL];
      en_pol    = lq.cfg_s2[DPOL_B_EN_POL];
      master_oe = lq.cfg_s2[DPOL_B_MASTER_OE];

      // Glass clock runs at half the link rate and never skips an edge,
      // even when the polarity changes; data moves on the edge opposite
      // to the one the panel captures on
      ld.phase                  = !lq.phase;
      ld.pins.panel_glass_clock = ld.phase;
      launch                    = (lq.phase == clk_pol);

      // Enable pin meaning depends on the panel type
      unique case (lq.mode_s2)
         DPOL_MODE_TFT:
            gen_level = en_pol ? timing.data_enable
                               : !timing.data_enable;
         DPOL_MODE_STN4,
         DPOL_MODE_STN8:
            gen_level = en_pol ? timing.shift_clock
                               : timing.line_toggle;
         default:
            gen_level = 1'b0;
      endcase

      if (launch) begin
         ld.pins.vsync = lq.cfg_s2[DPOL_B_VSYNC_POL] ? timing.vsync
                                                     : !timing.vsync;
         ld.pins.hsync = lq.cfg_s2[DPOL_B_HSYNC_POL] ? timing.hsync
                                                     : !timing.hsync;
         ld.pins.panel_enable_signal = gen_level;
      end

      ld.pins.panel_power_seq_port = lq.cfg_s2[DPOL_B_PWR_VAL];

      // A disabled port is left undriven for the general purpose pin
      ld.pins.vsync_oe = master_oe &&
                         lq.cfg_s2[DPOL_B_VSYNC_OE];
      ld.pins.hsync_oe = master_oe &&
                         lq.cfg_s2[DPOL_B_HSYNC_OE];
      ld.pins.panel_power_seq_port_oe = master_oe &&
                         lq.cfg_s2[DPOL_B_PWR_OE];
      ld.pins.panel_enable_signal_oe  = master_oe &&
                         lq.cfg_s2[DPOL_B_EN_OE];

      if (!lq.rst_s2) begin
         ld.phase = 1'b0;
         ld.pins  = '0;
      end
   end

   always_ff @(posedge lnk_clk) begin
      lq <= ld;
   end

   assign pins = lq.pins;

endmodule : dpol_port_ctrl

//--- test/dpol_panel.sv
// Purpose: Panel model that latches the pads on its glass clock edge
// Assumes: A pad whose enable is low floats and reads as z
// Notes:   Capture edge is strapped by the bench like a real panel
module dpol_panel (
   // Pads from the block
   input wire dpol_pkg::dpol_pins_t pins,
   // Strap and latched levels
   input wire logic                 cap_rise,
   output logic [3:0]               seen_q
);
   import dpol_pkg::*;
   logic [3:0] pad;
   assign pad = {pins.panel_power_seq_port_oe ? pins.panel_power_seq_port
                                              : 1'bz,
                 pins.panel_enable_signal_oe ? pins.panel_enable_signal
                                             : 1'bz,
                 pins.vsync_oe ? pins.vsync : 1'bz,
                 pins.hsync_oe ? pins.hsync : 1'bz};
   always @(posedge pins.panel_glass_clock)
      if (cap_rise) seen_q <= pad;
   always @(negedge pins.panel_glass_clock)
      if (!cap_rise) seen_q <= pad;
endmodule : dpol_panel

//--- test/dpol_port_ctrl_bench.sv
// Purpose: Self-checking bench for the polarity and pad enable block
// Assumes: Row = {mode, control three, timing}
// Notes:   Timing levels are held still so either capture edge agrees
module dpol_port_ctrl_bench;
   import dpol_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, lnk_clk, cap_rise;
   dpol_axi_req_t rq;
   dpol_axi_rsp_t rs;
   dpol_timing_t  tm, tm_d;
   dpol_pins_t    pins;
   logic [3:0]    seen;
   int            failures, checks;
   dpol_port_ctrl dpol_port_ctrl_i (.mclk(mclk), .resetn(resetn),
      .axi_req(rq), .axi_rsp(rs), .lnk_clk(lnk_clk), .timing(tm),
      .pins(pins));
   dpol_panel dpol_panel_i (.pins(pins), .cap_rise(cap_rise),
      .seen_q(seen));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      lnk_clk = 1'b0;
      #3;
      forever #6 lnk_clk = ~lnk_clk;
   end
   always @(posedge lnk_clk)
      tm <= tm_d;
   // ----------------------------------------------------------------
   // Bus and check helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge mclk);
      n = 0;
      rq.awaddr <= {24'h0, a};
      rq.wdata <= d;
      rq.wstrb <= s;
      rq.awvalid <= 1'b1;
      rq.wvalid <= 1'b1;
      rq.bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (rs.awready === 1'b1)
            rq.awvalid <= 1'b0;
         if (rs.wready === 1'b1)
            rq.wvalid <= 1'b0;
      end while (rs.bvalid !== 1'b1 && ++n < 100);
      if (rs.bvalid !== 1'b1)
         failures++;
      r = rs.bresp;
      rq.bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge mclk);
      n = 0;
      rq.araddr <= {24'h0, a};
      rq.arvalid <= 1'b1;
      rq.rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (rs.arready === 1'b1)
            rq.arvalid <= 1'b0;
      end while (rs.rvalid !== 1'b1 && ++n < 100);
      if (rs.rvalid !== 1'b1)
         failures++;
      d = rs.rdata;
      r = rs.rresp;
      rq.rready <= 1'b0;
   endtask : rd
   function automatic logic [3:0] pin_exp(input logic [17:0] w);
      logic [9:0]   c;
      dpol_timing_t t;
      logic         e;
      c = w[14:5];
      t = w[4:0];
      e = 1'b0;
      if (w[17:15] == DPOL_MODE_TFT)
         e = t.data_enable ^ ~c[6];
      if (w[17:15] == DPOL_MODE_STN4 || w[17:15] == DPOL_MODE_STN8)
         e = c[6] ? t.shift_clock : t.line_toggle;
      pin_exp = {c[8], e, t.vsync ^ ~c[5], t.hsync ^ ~c[4]};
      for (int i = 0; i < 4; i++)
         if (!(c[9] && c[i]))
            pin_exp[i] = 1'bz;
   endfunction : pin_exp
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd(DPOL_ADDR_CTL3, d, r);
      chk("ctl3 reset", d, {16'h0, DPOL_CTL3_RESET});
      rd(8'h0c, d, r);
      chk("unmapped data", d, 32'h0);
      chk("unmapped rresp", {30'h0, r}, {30'h0, DPOL_RESP_SLVERR});
      wr(8'h0c, 32'hffff_ffff, 4'hf, r);
      chk("unmapped bresp", {30'h0, r}, {30'h0, DPOL_RESP_SLVERR});
   endtask : t_reset
   task automatic t_pins;
      logic [17:0] w [7];
      logic [31:0] d;
      logic [1:0]  r;
      w = '{{3'h1, 10'h3ff, 5'h14}, {3'h1, 10'h20f, 5'h14},
            {3'h2, 10'h34f, 5'h0a}, {3'h3, 10'h38f, 5'h01},
            {3'h0, 10'h2ff, 5'h1f}, {3'h1, 10'h0ff, 5'h1f},
            {3'h1, 10'h305, 5'h10}};
      foreach (w[i]) begin
         wr(DPOL_ADDR_CTL2, {29'h0, w[i][17:15]}, 4'hf, r);
         wr(DPOL_ADDR_CTL3, {22'h0, w[i][14:5]}, 4'hf, r);
         tm_d = w[i][4:0];
         cap_rise = w[i][12];
         repeat (20) @(posedge mclk);
         chk("pads", {28'h0, seen}, {28'h0, pin_exp(w[i])});
         rd(DPOL_ADDR_CTL3, d, r);
         chk("ctl3 readback", d, {22'h0, w[i][14:5]});
         rd(DPOL_ADDR_STAT, d, r);
         chk("status", d, {28'h0, w[i][14] ? w[i][8:5] : 4'h0});
      end
   endtask : t_pins
   task automatic t_misc;
      logic [31:0] d;
      logic [1:0]  r;
      wr(DPOL_ADDR_CTL3, 32'h0, 4'hf, r);
      wr(DPOL_ADDR_CTL3, 32'hffff_ffff, 4'h2, r);
      rd(DPOL_ADDR_CTL3, d, r);
      chk("ctl3 lane one", d, 32'h300);
      wr(DPOL_ADDR_STAT, 32'hf, 4'hf, r);
      chk("status bresp", {30'h0, r}, {30'h0, DPOL_RESP_OKAY});
      rd(DPOL_ADDR_STAT, d, r);
      chk("status kept", d, 32'h0);
   endtask : t_misc
   task automatic wrap_up;
      if (failures == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial begin
      #100us;
      failures++;
      wrap_up();
   end
   initial begin
      rq = '0;
      tm = '0;
      tm_d = '0;
      cap_rise = 1'b0;
      resetn = 1'b0;
      failures = 0;
      checks = 0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_pins();
      t_misc();
      wrap_up();
   end
endmodule : dpol_port_ctrl_bench

//--- test/dpol_port_ctrl_props.sv
// Purpose: Bus handshake and link pin properties of the polarity block
// Assumes: Sees only the ports of dpol_port_ctrl
// Notes:   Link checks wait until the reset synchroniser has let go
module dpol_port_ctrl_props (
   // Clocks and reset
   input wire logic                    mclk,
   input wire logic                    resetn,
   input wire logic                    lnk_clk,
   // Bus and pads
   input wire dpol_pkg::dpol_axi_req_t axi_req,
   input wire dpol_pkg::dpol_axi_rsp_t axi_rsp,
   input wire dpol_pkg::dpol_pins_t    pins
);
   import dpol_pkg::*;
   // ----------------------------------------------------------------
   // Link reset shadow
   // ----------------------------------------------------------------
   logic [4:0] lrst_q = 5'h00;
   always_ff @(posedge lnk_clk)
      lrst_q <= {lrst_q[3:0], resetn};
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_glass_toggle: assert property (@(posedge lnk_clk)
      disable iff (lrst_q != 5'h1f)
      pins.panel_glass_clock != $past(pins.panel_glass_clock))
      else $error("glass clock stalled");
   a_aw_once: assert property (@(posedge mclk) disable iff (!resetn)
      axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
      else $error("awready stayed high");
   a_w_once: assert property (@(posedge mclk) disable iff (!resetn)
      axi_req.wvalid && axi_rsp.wready |=> !axi_rsp.wready)
      else $error("wready stayed high");
   a_b_time: assert property (@(posedge mclk) disable iff (!resetn)
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
      axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
      else $error("write response late");
   a_b_hold: assert property (@(posedge mclk) disable iff (!resetn)
      axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write response dropped");
   a_b_quiet: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(axi_rsp.bvalid) |-> axi_rsp.awready && axi_rsp.wready)
      else $error("write halves not freed at commit");
   a_ar_answer: assert property (@(posedge mclk) disable iff (!resetn)
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   a_r_hold: assert property (@(posedge mclk) disable iff (!resetn)
      axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data dropped");
   a_ar_block: assert property (@(posedge mclk) disable iff (!resetn)
      axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read taken while answer pending");
   c_write: cover property (@(posedge mclk) axi_rsp.bvalid);
   c_read: cover property (@(posedge mclk) axi_rsp.rvalid);
   c_hs_pad: cover property (@(posedge lnk_clk) pins.hsync_oe);
endmodule : dpol_port_ctrl_props

bind dpol_port_ctrl dpol_port_ctrl_props dpol_port_ctrl_props_i (
   .mclk(mclk), .resetn(resetn), .lnk_clk(lnk_clk),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins));
